//--- logic/fspg_defs.svh
// Constants for the flash self-program guard: section sizes, timing counts, reset values.
// Assumes word-addressed program flash of 16K words and a single core clock.
`ifndef FSPG_DEFS_SVH
`define FSPG_DEFS_SVH

`define FSPG_ADDR_W          14
`define FSPG_FLASH_TOP       14'h3FFF
`define FSPG_HALTING_SECTION_START      14'h3800
`define FSPG_BOOT_START_0    14'h3800
`define FSPG_BOOT_START_1    14'h3C00
`define FSPG_BOOT_START_2    14'h3E00
`define FSPG_BOOT_START_3    14'h3F00
`define FSPG_ARM_CYCLES      3'h4
`define FSPG_LOCK_RESET      4'hF
`define FSPG_BLOCKED_DATA    8'hFF
`define FSPG_LOCK_APP_WR     0
`define FSPG_LOCK_APP_RD     1
`define FSPG_LOCK_LDR_WR     2
`define FSPG_LOCK_LDR_RD     3

`endif

//--- logic/fspg_pkg.sv
// Types shared by the flash self-program guard.
// Assumes fspg_defs.svh is on the include path.
`include "fspg_defs.svh"

package fspg_pkg;

	// Command armed by the control register write
	typedef enum logic [2:0] {
		FSPG_CMD_BUFFER,
		FSPG_CMD_ERASE,
		FSPG_CMD_WRITE,
		FSPG_CMD_LOCK_SET,
		FSPG_CMD_REENABLE
	} fspg_cmd_t;

	// Programming engine state
	typedef enum logic [1:0] {
		FSPG_IDLE,
		FSPG_ARMED,
		FSPG_BUSY
	} fspg_state_t;

endpackage : fspg_pkg

//--- logic/fspg_lock_store.sv
// Boot lock bit store: four bits, one when unprogrammed.
// Assumes the chip-erase strobe comes only from the external programming path.
`timescale 1ns/1ps
`include "fspg_defs.svh"

module fspg_lock_store
	import fspg_pkg::*;
(
	// Clock and control
	input  wire logic       mclk_in,
	input  wire logic       reset_n_in,
	input  wire logic       clk_en_in,
	// Update sources
	input  wire logic       sw_set_in,
	input  wire logic [3:0] sw_data_in,
	input  wire logic       ext_prog_in,
	input  wire logic [3:0] ext_data_in,
	input  wire logic       chip_erase_in,
	// Stored value
	output logic      [3:0] lock_bits_out
);

	logic [3:0] lock_reg;

	// Bits only go to zero except through chip erase; reset loads the erased value, all ones
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			lock_reg <= `FSPG_LOCK_RESET;
		end else if (clk_en_in) begin
			if (chip_erase_in) begin
				lock_reg <= `FSPG_LOCK_RESET;
			end else if (ext_prog_in) begin
				lock_reg <= lock_reg & ext_data_in;
			end else if (sw_set_in) begin
				lock_reg <= lock_reg & sw_data_in;
			end
		end
	end

	assign lock_bits_out = lock_reg;

endmodule : fspg_lock_store

//--- logic/fspg_guard.sv
// Flash self-program guard: decides store and load access, stalls the core, tracks busy.
// Assumes the core presents one-cycle request strobes and a flash macro signals op_done.
`timescale 1ns/1ps
`include "fspg_defs.svh"

// Overview of operation
// - Program-store starts programming only when executed from the loader section.
// - From the loader section, stores may target any flash address, subject to locks.
// - Loader boundary comes from boot size fuses, never from a runtime register.
// - Programming a concurrent-read page keeps the CPU running.
// - Programming a halting-section page stalls the CPU for the whole operation.
// - Stall choice depends on the target page section, not the fetch section.
// - Busy flag reads one while the concurrent-read section is blocked.
// - Loader section lies inside the halting section for every boot size.
// - Lock bits set by software or programmer; cleared only by chip erase or reset.
// - General write-lock mode does not gate program-store writes.
// - General read/write-lock mode does not gate program-load or program-store.
// - App protection mode 1 imposes no restriction on application access.
// - Low app-protection bit programmed blocks stores into the application section.
// - High app-protection bit blocks loader-code loads from the application section.
// - High app-protection bit with loader vectors masks interrupts in application code.
// - Loader protection mode 1 imposes no restriction on loader access.
// - Low loader-protection bit programmed blocks stores into the loader section.
// - High loader-protection bit blocks application-code loads from the loader section.
// - High loader-protection bit with application vectors masks interrupts in loader code.
// - Busy sets on concurrent-section erase or write; clears on reenable or page load.
// - Armed lock-set plus store within four cycles writes lock bits from R0.
// - Store enable stays high until a page erase or write finishes.
module fspg_guard
	import fspg_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        mclk_in,
	input  wire logic        reset_n_in,
	input  wire logic        clk_en_in,
	// Configuration
	input  wire logic [1:0]  boot_size_fuses_in,
	input  wire logic        vectors_in_loader_in,
	// Control register write (one-cycle strobe)
	input  wire logic        ctrl_wr_in,
	input  wire logic        store_enable_in,
	input  wire logic        erase_cmd_in,
	input  wire logic        write_cmd_in,
	input  wire logic        lock_set_command_in,
	input  wire logic        concurrent_read_reenable_in,
	// Core requests
	input  wire logic [13:0] pc_in,
	input  wire logic        store_req_in,
	input  wire logic [13:0] store_addr_in,
	input  wire logic [7:0]  r0_data_in,
	input  wire logic        load_req_in,
	input  wire logic [13:0] load_addr_in,
	input  wire logic [7:0]  load_flash_data_in,
	// Flash macro handshake
	input  wire logic        op_done_in,
	// External programming path
	input  wire logic        ext_prog_in,
	input  wire logic [3:0]  ext_lock_data_in,
	input  wire logic        chip_erase_in,
	// Flash macro commands
	output logic             flash_erase_out,
	output logic             flash_write_out,
	output logic             flash_buffer_out,
	output logic [13:0]      flash_addr_out,
	// Core-facing results
	output logic [7:0]       load_data_out,
	output logic             load_valid_out,
	output logic             cpu_stall_out,
	output logic             irq_disable_out,
	// Status
	output logic             store_enable_out,
	output logic             concurrent_section_busy_out,
	output logic [3:0]       lock_bits_out
);

	// Engine state, latched command and window counter
	fspg_state_t     state_reg;
	fspg_cmd_t       cmd_reg;
	logic [2:0]      arm_cnt_reg;
	logic            halt_op_reg;
	logic            busy_reg;
	// Section decode and access decisions
	logic [13:0]     boot_start;
	logic            pc_in_loader;
	logic            st_tgt_loader;
	logic            ld_tgt_loader;
	logic            st_allowed;
	logic            ld_blocked;
	logic            store_go;
	logic            lock_set_go;
	logic [3:0]      lock_bits;
	// Registered outputs toward the flash macro and the core
	logic [13:0]     addr_reg;
	logic            erase_reg;
	logic            write_reg;
	logic            buffer_reg;
	logic [7:0]      load_data_reg;
	logic            load_valid_reg;

	// Loader start from fuses only; every choice sits at or above the halting boundary
	// A larger loader moves its start down; the halting boundary stays where it is
	always_comb begin
		case (boot_size_fuses_in)
			2'h0:    boot_start = `FSPG_BOOT_START_0;
			2'h1:    boot_start = `FSPG_BOOT_START_1;
			2'h2:    boot_start = `FSPG_BOOT_START_2;
			default: boot_start = `FSPG_BOOT_START_3;
		endcase
	end

	// Section decode of fetch and targets
	assign pc_in_loader  = (pc_in >= boot_start);
	assign st_tgt_loader = (store_addr_in >= boot_start);
	assign ld_tgt_loader = (load_addr_in >= boot_start);

	// Store access decision; general lock modes are deliberately not inputs here
	// Application code is refused outright, so it can never replace the loader
	always_comb begin
		st_allowed = pc_in_loader;
		if (st_tgt_loader) begin
			st_allowed = st_allowed & lock_bits[`FSPG_LOCK_LDR_WR];
		end else begin
			st_allowed = st_allowed & lock_bits[`FSPG_LOCK_APP_WR];
		end
	end

	// Load decision: cross-section reads blocked by the high protection bits
	// Same-section reads are never blocked; only cross-section reads obey the read bits
	always_comb begin
		ld_blocked = 1'b0;
		if (pc_in_loader && !ld_tgt_loader && !lock_bits[`FSPG_LOCK_APP_RD]) begin
			ld_blocked = 1'b1;
		end
		if (!pc_in_loader && ld_tgt_loader && !lock_bits[`FSPG_LOCK_LDR_RD]) begin
			ld_blocked = 1'b1;
		end
	end

	// Interrupt masking in modes 3 and 4 depending on vector placement
	// The mask follows the fetch address combinationally, so it tracks every jump at once
	always_comb begin
		irq_disable_out = 1'b0;
		if (vectors_in_loader_in && !pc_in_loader && !lock_bits[`FSPG_LOCK_APP_RD]) begin
			irq_disable_out = 1'b1;
		end
		if (!vectors_in_loader_in && pc_in_loader && !lock_bits[`FSPG_LOCK_LDR_RD]) begin
			irq_disable_out = 1'b1;
		end
	end

	// A store counts only inside the arming window; a lock set also needs loader code
	assign store_go    = (state_reg == FSPG_ARMED) && store_req_in;
	assign lock_set_go = store_go && (cmd_reg == FSPG_CMD_LOCK_SET) && pc_in_loader;

	// Command arming, four-cycle window and busy hold
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			state_reg   <= FSPG_IDLE;
			cmd_reg     <= FSPG_CMD_BUFFER;
			arm_cnt_reg <= 3'h0;
			halt_op_reg <= 1'b0;
		end else if (clk_en_in) begin
			case (state_reg)
				// Control writes are heard only while idle; later ones are dropped
				FSPG_IDLE: begin
					if (ctrl_wr_in && store_enable_in) begin
						state_reg   <= FSPG_ARMED;
						arm_cnt_reg <= `FSPG_ARM_CYCLES;
						if (lock_set_command_in) begin
							cmd_reg <= FSPG_CMD_LOCK_SET;
						end else if (erase_cmd_in) begin
							cmd_reg <= FSPG_CMD_ERASE;
						end else if (write_cmd_in) begin
							cmd_reg <= FSPG_CMD_WRITE;
						end else if (concurrent_read_reenable_in) begin
							cmd_reg <= FSPG_CMD_REENABLE;
						end else begin
							cmd_reg <= FSPG_CMD_BUFFER;
						end
					end
				end
				FSPG_ARMED: begin
					// First store ends the window; a refused one needs a fresh arming write
					if (store_go) begin
						if ((cmd_reg == FSPG_CMD_ERASE || cmd_reg == FSPG_CMD_WRITE)
						    && st_allowed) begin
							state_reg   <= FSPG_BUSY;
							halt_op_reg <= (store_addr_in >= `FSPG_HALTING_SECTION_START);
						end else begin
							state_reg <= FSPG_IDLE;
						end
					end else if (arm_cnt_reg == 3'h1) begin
						state_reg <= FSPG_IDLE;
					end
					arm_cnt_reg <= arm_cnt_reg - 3'h1;
				end
				FSPG_BUSY: begin
					// Hold until the flash macro reports the end of the erase or write
					if (op_done_in) begin
						state_reg   <= FSPG_IDLE;
						halt_op_reg <= 1'b0;
					end
				end
				default: begin
					// Unused encoding falls back to idle
					state_reg <= FSPG_IDLE;
				end
			endcase
		end
	end

	// Store enable high while armed or programming
	assign store_enable_out = (state_reg != FSPG_IDLE);

	// Stall only when the programmed page is in the halting section
	// The fetch address plays no part, so loader code writing a halting page still stops
	assign cpu_stall_out = (state_reg == FSPG_BUSY) && halt_op_reg;

	// Concurrent-section busy tracking
	// Completion alone never clears the flag: software must reenable or load a page buffer first, so fetches
	// from a freshly written page cannot slip in before the flash has settled
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			busy_reg <= 1'b0;
		end else if (clk_en_in) begin
			if (store_go && st_allowed && (store_addr_in < `FSPG_HALTING_SECTION_START)
			    && (cmd_reg == FSPG_CMD_ERASE || cmd_reg == FSPG_CMD_WRITE)) begin
				busy_reg <= 1'b1;
			end else if (store_go && st_allowed && (cmd_reg == FSPG_CMD_BUFFER)) begin
				busy_reg <= 1'b0;
			end else if (store_go && (cmd_reg == FSPG_CMD_REENABLE)) begin
				busy_reg <= 1'b0;
			end
		end
	end

	// Busy flag as seen by software
	assign concurrent_section_busy_out = busy_reg;

	// Flash macro command strobes; blocked stores raise nothing
	// The address is taken at every store in the window, so the macro sees a stable page
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			erase_reg  <= 1'b0;
			write_reg  <= 1'b0;
			buffer_reg <= 1'b0;
			addr_reg   <= 14'h0000;
		end else if (clk_en_in) begin
			erase_reg  <= store_go && st_allowed && (cmd_reg == FSPG_CMD_ERASE);
			write_reg  <= store_go && st_allowed && (cmd_reg == FSPG_CMD_WRITE);
			buffer_reg <= store_go && st_allowed && (cmd_reg == FSPG_CMD_BUFFER);
			if (store_go) begin
				addr_reg <= store_addr_in;
			end
		end
	end

	// Strobes and address straight from flip-flops
	assign flash_erase_out  = erase_reg;
	assign flash_write_out  = write_reg;
	assign flash_buffer_out = buffer_reg;
	assign flash_addr_out   = addr_reg;

	// Load result; blocked reads give all ones
	// Valid follows every request, blocked or not, so the core never waits on a refusal
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			load_data_reg  <= 8'h00;
			load_valid_reg <= 1'b0;
		end else if (clk_en_in) begin
			load_valid_reg <= load_req_in;
			if (load_req_in) begin
				load_data_reg <= ld_blocked ? `FSPG_BLOCKED_DATA : load_flash_data_in;
			end
		end
	end

	// Load result from flip-flops
	assign load_data_out  = load_data_reg;
	assign load_valid_out = load_valid_reg;

	// Lock bit storage
	// Only the low nibble of the working register carries lock bits
	fspg_lock_store u_lock_store (
		.mclk_in       (mclk_in),
		.reset_n_in    (reset_n_in),
		.clk_en_in     (clk_en_in),
		.sw_set_in     (lock_set_go),
		.sw_data_in    (r0_data_in[3:0]),
		.ext_prog_in   (ext_prog_in),
		.ext_data_in   (ext_lock_data_in),
		.chip_erase_in (chip_erase_in),
		.lock_bits_out (lock_bits)
	);

	// Stored lock bits shown to software
	assign lock_bits_out = lock_bits;

endmodule : fspg_guard

//--- verification/fspg_guard_properties.sv
// Port-level checker for the flash self-program guard.
// Assumes one clock, synchronous active-low reset, bound below.
`timescale 1ns/1ps
`include "fspg_defs.svh"

module fspg_guard_props (
	// Clock, reset and configuration
	input wire logic        mclk_in,
	input wire logic        reset_n_in,
	input wire logic [1:0]  boot_size_fuses_in,
	input wire logic        vectors_in_loader_in,
	// Core requests and flash answers
	input wire logic [13:0] pc_in,
	input wire logic        store_req_in,
	input wire logic [13:0] store_addr_in,
	input wire logic        load_req_in,
	input wire logic [13:0] load_addr_in,
	input wire logic [7:0]  load_flash_data_in,
	input wire logic        op_done_in,
	input wire logic        chip_erase_in,
	// Guard outputs
	input wire logic        flash_erase_out,
	input wire logic        flash_write_out,
	input wire logic [7:0]  load_data_out,
	input wire logic        load_valid_out,
	input wire logic        cpu_stall_out,
	input wire logic        irq_disable_out,
	input wire logic        store_enable_out,
	input wire logic        concurrent_section_busy_out,
	input wire logic [3:0]  lock_bits_out
);
	logic [13:0] ldr_start;
	logic        in_ldr;
	logic        prog;

	// Loader start from the size fuses
	always_comb begin
		case (boot_size_fuses_in)
			2'h0: ldr_start = `FSPG_BOOT_START_0;
			2'h1: ldr_start = `FSPG_BOOT_START_1;
			2'h2: ldr_start = `FSPG_BOOT_START_2;
			default: ldr_start = `FSPG_BOOT_START_3;
		endcase
	end
	// Fetch section and programming strobe
	assign in_ldr = pc_in >= ldr_start;
	assign prog = flash_erase_out | flash_write_out;

	default clocking @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);

	app_store_off_a: assert property (store_req_in && !in_ldr |=> !prog)
		else $error("store from application code started programming");
	halt_stall_a: assert property (store_req_in && store_addr_in >= `FSPG_HALTING_SECTION_START ##1 prog
		|-> cpu_stall_out) else $error("halting section op without stall");
	rww_run_a: assert property (store_req_in && store_addr_in < `FSPG_HALTING_SECTION_START ##1 prog
		|-> !cpu_stall_out && concurrent_section_busy_out) else $error("concurrent op wrong");
	stall_hold_a: assert property (cpu_stall_out && !op_done_in
		|=> cpu_stall_out && store_enable_out) else $error("stall or enable dropped early");
	busy_hold_a: assert property (concurrent_section_busy_out && !store_req_in
		|=> concurrent_section_busy_out) else $error("busy flag cleared without store");
	load_block_a: assert property (load_req_in && in_ldr && load_addr_in < ldr_start
		&& !lock_bits_out[1] |=> load_valid_out && load_data_out == `FSPG_BLOCKED_DATA)
		else $error("blocked load returned flash data");
	load_open_a: assert property (load_req_in && lock_bits_out == 4'hF
		|=> load_valid_out && load_data_out == $past(load_flash_data_in))
		else $error("open load data wrong");
	lock_keep_a: assert property (!chip_erase_in
		|=> (lock_bits_out & ~$past(lock_bits_out)) == 4'h0) else $error("lock bit unprogrammed");
	irq_app_a: assert property (!in_ldr && vectors_in_loader_in && !lock_bits_out[1]
		|-> irq_disable_out) else $error("interrupts not masked in application code");
	store_block_a: assert property (store_req_in && store_addr_in < ldr_start
		&& !lock_bits_out[0] |=> !prog && !cpu_stall_out) else $error("locked store ran");
endmodule : fspg_guard_props

bind fspg_guard fspg_guard_props fspg_guard_props_inst (
	.mclk_in, .reset_n_in, .boot_size_fuses_in, .vectors_in_loader_in, .pc_in,
	.store_req_in, .store_addr_in, .load_req_in, .load_addr_in, .load_flash_data_in,
	.op_done_in, .chip_erase_in, .flash_erase_out, .flash_write_out, .load_data_out,
	.load_valid_out, .cpu_stall_out, .irq_disable_out, .store_enable_out,
	.concurrent_section_busy_out, .lock_bits_out
);

//--- verification/fspg_flash_model.sv
// Flash macro stand-in: times erase and write, serves load bytes.
// Assumes the guard's registered strobes in the same clock domain.
`timescale 1ns/1ps

module fspg_flash_model #(
	parameter int OP_CYCLES = 6
) (
	input  wire logic        mclk_in,
	input  wire logic        erase_in,
	input  wire logic        write_in,
	input  wire logic [13:0] load_addr_in,
	output logic             op_done_out,
	output logic [7:0]       load_flash_data_out
);
	int cnt = 0;

	// Count an operation down after each strobe
	always_ff @(posedge mclk_in) begin
		if (erase_in || write_in)
			cnt <= OP_CYCLES;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
	// One-cycle done pulse; bytes differ with address
	assign op_done_out = (cnt == 1);
	assign load_flash_data_out = load_addr_in[7:0] ^ 8'h3C;
endmodule : fspg_flash_model

//--- verification/tb_flash_self_program_guard.sv
// Self-checking bench for the flash self-program guard.
// Drives core requests at the falling edge; a flash stand-in answers.
`timescale 1ns/1ps

module tb_flash_self_program_guard;
	logic        mclk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic [1:0]  fuses = 2'h0;
	logic        vec_ldr = 1'b0;
	logic        ctrl_wr = 1'b0;
	logic [4:0]  cmd = 5'h00;
	logic [13:0] pc = 14'h3800;
	logic        st_req = 1'b0;
	logic [13:0] st_addr = 14'h0000;
	logic [7:0]  r0 = 8'h00;
	logic        ld_req = 1'b0;
	logic [13:0] ld_addr = 14'h0000;
	logic        ext_prog = 1'b0;
	logic [3:0]  ext_data = 4'h0;
	logic        chip_erase = 1'b0;
	logic        done, f_er, f_wr, f_buf, stall, irq, st_en, busy, ld_v;
	logic [7:0]  fdata, ld_d;
	logic [3:0]  locks;
	logic [13:0] f_addr;
	int          error_cnt = 0;
	int          checks_done = 0;

	fspg_guard fspg_guard_inst (
		.mclk_in, .reset_n_in, .clk_en_in(1'b1), .boot_size_fuses_in(fuses),
		.vectors_in_loader_in(vec_ldr), .ctrl_wr_in(ctrl_wr), .store_enable_in(cmd[0]),
		.erase_cmd_in(cmd[1]), .write_cmd_in(cmd[2]), .lock_set_command_in(cmd[3]),
		.concurrent_read_reenable_in(cmd[4]), .pc_in(pc), .store_req_in(st_req),
		.store_addr_in(st_addr), .r0_data_in(r0), .load_req_in(ld_req),
		.load_addr_in(ld_addr), .load_flash_data_in(fdata), .op_done_in(done),
		.ext_prog_in(ext_prog), .ext_lock_data_in(ext_data), .chip_erase_in(chip_erase),
		.flash_erase_out(f_er), .flash_write_out(f_wr), .flash_buffer_out(f_buf),
		.flash_addr_out(f_addr), .load_data_out(ld_d), .load_valid_out(ld_v),
		.cpu_stall_out(stall), .irq_disable_out(irq), .store_enable_out(st_en),
		.concurrent_section_busy_out(busy), .lock_bits_out(locks)
	);
	fspg_flash_model fspg_flash_model_inst (
		.mclk_in, .erase_in(f_er), .write_in(f_wr), .load_addr_in(ld_addr),
		.op_done_out(done), .load_flash_data_out(fdata)
	);

	// Clock of 20 ns period
	initial begin
		forever #10 mclk_in = ~mclk_in;
	end

	// Print counts and verdict, then stop
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	// Compare one value and count it
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Arm a command, then store in the next cycle
	task automatic op(input logic [4:0] c, input logic [13:0] a, input logic [7:0] d);
		@(negedge mclk_in);
		ctrl_wr = 1'b1;
		cmd = c;
		@(negedge mclk_in);
		ctrl_wr = 1'b0;
		cmd = 5'h00;
		st_req = 1'b1;
		st_addr = a;
		r0 = d;
		@(negedge mclk_in);
		st_req = 1'b0;
	endtask : op

	// One load from a fetch address; answer comes next cycle
	task automatic ld(input logic [13:0] p, input logic [13:0] a, input logic [7:0] e);
		@(negedge mclk_in);
		pc = p;
		ld_req = 1'b1;
		ld_addr = a;
		@(negedge mclk_in);
		ld_req = 1'b0;
		chk(ld_v, 8'h01);
		chk(ld_d, e);
	endtask : ld

	// Bounded wait for store enable to drop
	task automatic wait_idle();
		int n;
		n = 0;
		while (st_en === 1'b1 && n < 40) begin
			@(negedge mclk_in);
			n++;
		end
		if (n == 40) begin
			error_cnt++;
			wrap_up();
		end
	endtask : wait_idle

	// Buffer store fetched from just below and at the loader start, each size
	task automatic t_sizes();
		logic [13:0] s [4] = '{14'h3800, 14'h3C00, 14'h3E00, 14'h3F00};
		for (int i = 0; i < 4; i++) begin
			fuses = i[1:0];
			pc = s[i] - 14'h0001;
			op(5'h01, 14'h0010, 8'h00);
			chk(f_buf, 8'h00);
			pc = s[i];
			op(5'h01, 14'h0010, 8'h00);
			chk(f_buf, 8'h01);
		end
		fuses = 2'h0;
		$display("test sizes done");
	endtask : t_sizes

	// Erase in the concurrent section, read on, then reenable
	task automatic t_rww();
		pc = 14'h3800;
		op(5'h03, 14'h0100, 8'h00);
		chk(f_er, 8'h01);
		chk(f_addr, 16'h0100);
		chk(stall, 8'h00);
		chk(busy, 8'h01);
		ld(14'h3900, 14'h3A00, 8'h3C);
		wait_idle();
		chk(busy, 8'h01);
		op(5'h11, 14'h0000, 8'h00);
		chk(busy, 8'h00);
		ld(14'h3800, 14'h0142, 8'h7E);
		op(5'h05, 14'h0100, 8'h00);
		chk(busy, 8'h01);
		wait_idle();
		op(5'h01, 14'h0100, 8'h00);
		chk(f_buf, 8'h01);
		chk(busy, 8'h00);
		$display("test concurrent erase done");
	endtask : t_rww

	// Write a halting page from the loader with the loader starting at 3C00, below it
	task automatic t_halt();
		fuses = 2'h1;
		pc = 14'h3C10;
		op(5'h05, 14'h3900, 8'h00);
		chk(f_wr, 8'h01);
		chk(f_addr, 16'h3900);
		chk(stall, 8'h01);
		chk(busy, 8'h00);
		@(negedge mclk_in);
		chk(st_en, 8'h01);
		wait_idle();
		chk(stall, 8'h00);
		fuses = 2'h0;
		$display("test halting write done");
	endtask : t_halt

	// Store on the last cycle of the arming window, then one cycle too late
	task automatic t_window();
		pc = 14'h3800;
		for (int g = 3; g < 5; g++) begin
			@(negedge mclk_in);
			ctrl_wr = 1'b1;
			cmd = 5'h01;
			@(negedge mclk_in);
			ctrl_wr = 1'b0;
			cmd = 5'h00;
			repeat (g) @(negedge mclk_in);
			chk(st_en, (g == 3) ? 16'h0001 : 16'h0000);
			st_req = 1'b1;
			st_addr = 14'h0020;
			@(negedge mclk_in);
			st_req = 1'b0;
			chk(f_buf, (g == 3) ? 16'h0001 : 16'h0000);
		end
		$display("test window done");
	endtask : t_window

	// Lock set, blocked stores and loads, masking, chip erase
	task automatic t_locks();
		pc = 14'h3800;
		op(5'h09, 14'h0000, 8'hFA);
		chk(locks, 8'h0A);
		op(5'h03, 14'h0200, 8'h00);
		chk(f_er, 8'h00);
		chk(busy, 8'h00);
		op(5'h05, 14'h3880, 8'h00);
		chk(f_wr, 8'h00);
		chk(stall, 8'h00);
		op(5'h09, 14'h0000, 8'hFF);
		chk(locks, 8'h0A);
		ext_prog = 1'b1;
		ext_data = 4'h5;
		@(negedge mclk_in);
		ext_prog = 1'b0;
		chk(locks, 8'h00);
		ld(14'h3800, 14'h0200, 8'hFF);
		ld(14'h0100, 14'h3900, 8'hFF);
		vec_ldr = 1'b1;
		@(negedge mclk_in);
		chk(irq, 8'h01);
		vec_ldr = 1'b0;
		pc = 14'h3800;
		@(negedge mclk_in);
		chk(irq, 8'h01);
		chip_erase = 1'b1;
		@(negedge mclk_in);
		chip_erase = 1'b0;
		chk(locks, 8'h0F);
		chk(irq, 8'h00);
		ld(14'h3800, 14'h0200, 8'h3C);
		ld(14'h0100, 14'h3900, 8'h3C);
		$display("test locks done");
	endtask : t_locks

	// Reset, then the scenarios in turn
	initial begin
		repeat (20) @(negedge mclk_in);
		reset_n_in = 1'b1;
		@(negedge mclk_in);
		chk(locks, 8'h0F);
		chk(busy, 8'h00);
		chk(stall, 8'h00);
		t_sizes();
		t_rww();
		t_halt();
		t_window();
		t_locks();
		wrap_up();
	end
endmodule : tb_flash_self_program_guard
